// >>> src/bvsc_consts.vh
// Purpose: Shared constants for the buck voltage and slot configuration block.
// Assumes: Register indices are word indices; the bus byte address is four times the index.
// Notes:   Voltages are expressed in units of 0.1 mV.
`ifndef BVSC_CONSTS_VH
`define BVSC_CONSTS_VH

`define BVSC_IDX_RUN        16'h4058
`define BVSC_IDX_SLEEP      16'h4059
`define BVSC_IDX_SCALE      16'h405a
`define BVSC_IDX_B2A        16'h405b
`define BVSC_IDX_B2B        16'h405c
`define BVSC_NREGS          5
`define BVSC_SEL_NONE       3'h7

`define BVSC_F_VCODE        6:0
`define BVSC_F_VHI          6:2
`define BVSC_F_VLO          1:0
`define BVSC_F_SLOT         15:13
`define BVSC_F_MODE         9:8
`define BVSC_F_SRC          12:11
`define BVSC_F_FREQ         9:8
`define BVSC_F_CAP          1:0
`define BVSC_F_ERRACT       15:14
`define BVSC_F_HWCSRC       12:11
`define BVSC_B_HWCVSEL      10
`define BVSC_F_HWCMODE      9:8

`define BVSC_MASK_RUN       16'h007f
`define BVSC_MASK_SLEEP     16'he37f
`define BVSC_MASK_SCALE     16'h187f
`define BVSC_MASK_B2A       16'hd3b3
`define BVSC_MASK_B2A_LOAD  16'h0303
`define BVSC_MASK_B2B       16'hdf00

`define BVSC_RST_RUN        16'h0000
`define BVSC_RST_SLEEP      16'h0000
`define BVSC_RST_SCALE      16'h0000
`define BVSC_RST_B2A        16'h8000
`define BVSC_RST_B2B        16'h0300

`define BVSC_V_MIN_CODE     7'h08
`define BVSC_V_MAX_CODE     7'h68
`define BVSC_V_BASE         15'h1770
`define BVSC_V_STEP         15'h007d
`define BVSC_V_TOP          15'h4650

`define BVSC_SLOT_SLP_TS5   3'h0
`define BVSC_SLOT_SLP_TS3   3'h6
`define BVSC_SLOT_SLP_TS1   3'h7
`define BVSC_TS5            3'h5
`define BVSC_TS3            3'h3
`define BVSC_TS1            3'h1
`define BVSC_SLOT_DIS_BASE  3'h6

`define BVSC_SRC_OFF        2'h0
`define BVSC_SRC_ON         2'h1
`define BVSC_SRC_IN1        2'h2
`define BVSC_SRC_IN2        2'h3
`define BVSC_HWC_IN1        2'h1
`define BVSC_HWC_IN2        2'h2
`define BVSC_HWC_ANY        2'h3

`define BVSC_FREQ_2MHZ      2'h1
`define BVSC_FREQ_4MHZ      2'h2
`define BVSC_CAP_OK         2'h2
`define BVSC_ERR_CONV       2'h1
`define BVSC_ERR_SYS        2'h2

`define BVSC_RESP_OKAY      2'h0
`define BVSC_RESP_SLVERR    2'h2
`define BVSC_NSYNC          12

`endif

// >>> src/bvsc_vdecode.v
// Purpose: Maps a 7-bit converter voltage code to an output level in 0.1 mV units.
// Assumes: Purely combinational; the caller registers the result.
// Notes:   Codes at or below the floor clamp low, codes at or above the ceiling clamp high.
`timescale 1ns/1ps
`include "bvsc_consts.vh"

module bvsc_vdecode (
   input  wire [6:0]  code,
   output reg  [14:0] level
);
   wire [6:0]  steps;
   wire [14:0] prod;

   assign steps = code - `BVSC_V_MIN_CODE;
   assign prod  = {8'h00, steps} * `BVSC_V_STEP;

   always @* begin
      if (code <= `BVSC_V_MIN_CODE) begin
         level = `BVSC_V_BASE;
      end else if (code >= `BVSC_V_MAX_CODE) begin
         level = `BVSC_V_TOP;
      end else begin
         level = `BVSC_V_BASE + prod;
      end
   end
endmodule

// >>> src/bvsc_top.v
// Purpose: Configuration registers and decoders for two step-down converters.
// Assumes: AXI4-Lite slave, one clock, pins synchronised by two flip-flops.
// Notes:   Register contents sit in the low 16 bits of each word; upper bits read zero.
`timescale 1ns/1ps
`include "bvsc_consts.vh"

module bvsc_top (
   input  wire        CLOCK,
   input  wire        RST_N,
   input  wire [31:0] S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output wire        S_AXI_AWREADY,
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output wire        S_AXI_WREADY,
   output reg  [1:0]  S_AXI_BRESP,
   output reg         S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   input  wire [31:0] S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output wire        S_AXI_ARREADY,
   output reg  [31:0] S_AXI_RDATA,
   output reg  [1:0]  S_AXI_RRESP,
   output reg         S_AXI_RVALID,
   input  wire        S_AXI_RREADY,
   input  wire        HW_ENABLE_ASSIGNED,
   input  wire        HW_SCALING_INPUT_1,
   input  wire        HW_SCALING_INPUT_2,
   input  wire        HW_CTRL_INPUT_1,
   input  wire        HW_CTRL_INPUT_2,
   input  wire        BUCK2_FAULT,
   input  wire        CFG_LOADING,
   input  wire [4:0]  OTP_RUN_CODE_HI,
   output reg  [14:0] BUCK1_RUN_VOLTAGE,
   output reg  [14:0] BUCK1_SLEEP_VOLTAGE,
   output reg  [14:0] BUCK1_SCALING_VOLTAGE,
   output reg  [14:0] BUCK1_TARGET_VOLTAGE,
   output reg         BUCK1_SCALING_ACTIVE,
   output reg  [2:0]  BUCK1_SLEEP_TIMESLOT,
   output reg         BUCK1_SLEEP_DISABLES,
   output reg  [3:0]  BUCK1_SLEEP_MODE_OH,
   output reg         BUCK2_FREQ_2MHZ,
   output reg         BUCK2_FREQ_4MHZ,
   output reg         BUCK2_CAP_VALID,
   output reg         BUCK2_HWC_ACTIVE,
   output reg         BUCK2_HWC_USE_SLEEP_CODE,
   output reg  [3:0]  BUCK2_HWC_MODE_OH,
   output reg         BUCK2_FAULT_IRQ,
   output reg         BUCK2_SHUTDOWN,
   output reg         SYSTEM_RESET_REQ
);
   reg  [15:0] cfg_reg [0:`BVSC_NREGS-1];
   reg  [`BVSC_NSYNC-1:0] sync1_reg;
   reg  [`BVSC_NSYNC-1:0] sync2_reg;
   reg         loading_d_reg;
   reg         fault_d_reg;
   reg         aw_got_reg;
   reg         w_got_reg;
   reg  [31:0] aw_addr_reg;
   reg  [15:0] w_data_reg;
   reg  [1:0]  w_strb_reg;
   wire [2:0]  wsel;
   wire [2:0]  rsel;
   wire [15:0] wmerge_mask;
   wire        do_write;
   wire        hw_en_s;
   wire        scale1_s;
   wire        scale2_s;
   wire        hwc1_s;
   wire        hwc2_s;
   wire        fault_s;
   wire        loading_s;
   wire [4:0]  otp_hi_s;
   wire        load_start;
   wire [6:0]  vcode [0:2];
   wire [14:0] vlevel [0:2];
   reg         scaling_next;
   reg         hwc_next;
   reg  [2:0]  slot_next;
   reg         slot_dis_next;
   integer     i;
   genvar      g;

   // Register index of an aligned word address, or none when unmapped.
   function [2:0] reg_sel;
      input [31:0] addr;
      begin
         if (addr[1:0] != 2'h0 || addr[31:18] != 14'h0000) begin
            reg_sel = `BVSC_SEL_NONE;
         end else begin
            case (addr[17:2])
               `BVSC_IDX_RUN:   reg_sel = 3'h0;
               `BVSC_IDX_SLEEP: reg_sel = 3'h1;
               `BVSC_IDX_SCALE: reg_sel = 3'h2;
               `BVSC_IDX_B2A:   reg_sel = 3'h3;
               `BVSC_IDX_B2B:   reg_sel = 3'h4;
               default:         reg_sel = `BVSC_SEL_NONE;
            endcase
         end
      end
   endfunction

   // Writable bits per register; the load-only fields open up during a configuration load.
   function [15:0] wr_mask;
      input [2:0] sel;
      input       loading;
      begin
         case (sel)
            3'h0:    wr_mask = `BVSC_MASK_RUN;
            3'h1:    wr_mask = `BVSC_MASK_SLEEP;
            3'h2:    wr_mask = `BVSC_MASK_SCALE;
            3'h3:    wr_mask = loading ? `BVSC_MASK_B2A : (`BVSC_MASK_B2A & ~`BVSC_MASK_B2A_LOAD);
            3'h4:    wr_mask = `BVSC_MASK_B2B;
            default: wr_mask = 16'h0000;
         endcase
      end
   endfunction

   function [15:0] rst_val;
      input [2:0] sel;
      begin
         case (sel)
            3'h0:    rst_val = `BVSC_RST_RUN;
            3'h1:    rst_val = `BVSC_RST_SLEEP;
            3'h2:    rst_val = `BVSC_RST_SCALE;
            3'h3:    rst_val = `BVSC_RST_B2A;
            3'h4:    rst_val = `BVSC_RST_B2B;
            default: rst_val = 16'h0000;
         endcase
      end
   endfunction

   // One-hot mode: bit 0 forced continuous, bit 1 auto or disabled, bit 2 linear, bit 3 hysteretic.
   function [3:0] mode_oh;
      input [1:0] m;
      begin
         mode_oh = 4'h1 << m;
      end
   endfunction

   // Pins come from other domains, so nothing but the second stage is read.
   always @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         sync1_reg <= 12'h000;
         sync2_reg <= 12'h000;
      end else begin
         sync1_reg <= {OTP_RUN_CODE_HI, CFG_LOADING, BUCK2_FAULT, HW_CTRL_INPUT_2, HW_CTRL_INPUT_1,
                       HW_SCALING_INPUT_2, HW_SCALING_INPUT_1, HW_ENABLE_ASSIGNED};
         sync2_reg <= sync1_reg;
      end
   end

   assign hw_en_s   = sync2_reg[0];
   assign scale1_s  = sync2_reg[1];
   assign scale2_s  = sync2_reg[2];
   assign hwc1_s    = sync2_reg[3];
   assign hwc2_s    = sync2_reg[4];
   assign fault_s   = sync2_reg[5];
   assign loading_s = sync2_reg[6];
   assign otp_hi_s  = sync2_reg[11:7];
   assign load_start = loading_s & ~loading_d_reg;

   // Write channel: address and data are taken in either order, one write at a time.
   assign S_AXI_AWREADY = ~aw_got_reg & ~S_AXI_BVALID;
   assign S_AXI_WREADY  = ~w_got_reg & ~S_AXI_BVALID;
   assign do_write      = aw_got_reg & w_got_reg & ~S_AXI_BVALID;
   assign wsel          = reg_sel(aw_addr_reg);
   assign wmerge_mask   = wr_mask(wsel, loading_s) & {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   assign S_AXI_ARREADY = ~S_AXI_RVALID;
   assign rsel          = reg_sel(S_AXI_ARADDR);

   always @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         aw_got_reg   <= 1'b0;
         w_got_reg    <= 1'b0;
         aw_addr_reg  <= 32'h00000000;
         w_data_reg   <= 16'h0000;
         w_strb_reg   <= 2'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= `BVSC_RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_got_reg  <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_got_reg  <= 1'b1;
            w_data_reg <= S_AXI_WDATA[15:0];
            w_strb_reg <= S_AXI_WSTRB[1:0];
         end
         if (do_write) begin
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= (wsel == `BVSC_SEL_NONE) ? `BVSC_RESP_SLVERR : `BVSC_RESP_OKAY;
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // A load start in the same cycle as a bus write to the run register overrides the whole code: upper bits from OTP, low bits cleared.
   always @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         for (i = 0; i < `BVSC_NREGS; i = i + 1) begin
            cfg_reg[i] <= rst_val(i[2:0]);
         end
         loading_d_reg <= 1'b0;
      end else begin
         loading_d_reg <= loading_s;
         if (do_write && wsel != `BVSC_SEL_NONE) begin
            cfg_reg[wsel] <= (cfg_reg[wsel] & ~wmerge_mask) | (w_data_reg & wmerge_mask);
         end
         if (load_start) begin
            cfg_reg[0][`BVSC_F_VHI] <= otp_hi_s;
            cfg_reg[0][`BVSC_F_VLO] <= 2'h0;
         end
      end
   end

   always @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA  <= 32'h00000000;
         S_AXI_RRESP  <= `BVSC_RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         if (rsel == `BVSC_SEL_NONE) begin
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `BVSC_RESP_SLVERR;
         end else begin
            S_AXI_RDATA <= {16'h0000, cfg_reg[rsel]};
            S_AXI_RRESP <= `BVSC_RESP_OKAY;
         end
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   // The run, sleep and scaling codes share one decoder shape.
   assign vcode[0] = cfg_reg[0][`BVSC_F_VCODE];
   assign vcode[1] = cfg_reg[1][`BVSC_F_VCODE];
   assign vcode[2] = cfg_reg[2][`BVSC_F_VCODE];

   generate
      for (g = 0; g < 3; g = g + 1) begin : g_vdec
         bvsc_vdecode u_vdec (
            .code  (vcode[g]),
            .level (vlevel[g])
         );
      end
   endgenerate

   always @* begin
      case (cfg_reg[2][`BVSC_F_SRC])
         `BVSC_SRC_OFF: scaling_next = 1'b0;
         `BVSC_SRC_ON:  scaling_next = 1'b1;
         `BVSC_SRC_IN1: scaling_next = scale1_s;
         `BVSC_SRC_IN2: scaling_next = scale2_s;
         default:       scaling_next = 1'b0;
      endcase
      case (cfg_reg[4][`BVSC_F_HWCSRC])
         `BVSC_HWC_IN1: hwc_next = hwc1_s;
         `BVSC_HWC_IN2: hwc_next = hwc2_s;
         `BVSC_HWC_ANY: hwc_next = hwc1_s | hwc2_s;
         default:       hwc_next = 1'b0;
      endcase
      slot_dis_next = 1'b0;
      case (cfg_reg[1][`BVSC_F_SLOT])
         `BVSC_SLOT_SLP_TS5: slot_next = `BVSC_TS5;
         `BVSC_SLOT_SLP_TS3: slot_next = `BVSC_TS3;
         `BVSC_SLOT_SLP_TS1: slot_next = `BVSC_TS1;
         default: begin
            slot_next     = `BVSC_SLOT_DIS_BASE - cfg_reg[1][`BVSC_F_SLOT];
            slot_dis_next = ~hw_en_s;
         end
      endcase
   end

   always @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         BUCK1_RUN_VOLTAGE        <= `BVSC_V_BASE;
         BUCK1_SLEEP_VOLTAGE      <= `BVSC_V_BASE;
         BUCK1_SCALING_VOLTAGE    <= `BVSC_V_BASE;
         BUCK1_TARGET_VOLTAGE     <= `BVSC_V_BASE;
         BUCK1_SCALING_ACTIVE     <= 1'b0;
         BUCK1_SLEEP_TIMESLOT     <= `BVSC_TS5;
         BUCK1_SLEEP_DISABLES     <= 1'b0;
         BUCK1_SLEEP_MODE_OH      <= 4'h1;
         BUCK2_FREQ_2MHZ          <= 1'b0;
         BUCK2_FREQ_4MHZ          <= 1'b0;
         BUCK2_CAP_VALID          <= 1'b0;
         BUCK2_HWC_ACTIVE         <= 1'b0;
         BUCK2_HWC_USE_SLEEP_CODE <= 1'b0;
         BUCK2_HWC_MODE_OH        <= 4'h0;
      end else begin
         BUCK1_RUN_VOLTAGE        <= vlevel[0];
         BUCK1_SLEEP_VOLTAGE      <= vlevel[1];
         BUCK1_SCALING_VOLTAGE    <= vlevel[2];
         BUCK1_TARGET_VOLTAGE     <= scaling_next ? vlevel[2] : vlevel[0];
         BUCK1_SCALING_ACTIVE     <= scaling_next;
         BUCK1_SLEEP_TIMESLOT     <= slot_next;
         BUCK1_SLEEP_DISABLES     <= slot_dis_next;
         BUCK1_SLEEP_MODE_OH      <= mode_oh(cfg_reg[1][`BVSC_F_MODE]);
         BUCK2_FREQ_2MHZ          <= cfg_reg[3][`BVSC_F_FREQ] == `BVSC_FREQ_2MHZ;
         BUCK2_FREQ_4MHZ          <= cfg_reg[3][`BVSC_F_FREQ] == `BVSC_FREQ_4MHZ;
         BUCK2_CAP_VALID          <= cfg_reg[3][`BVSC_F_CAP] == `BVSC_CAP_OK;
         BUCK2_HWC_ACTIVE         <= hwc_next;
         BUCK2_HWC_USE_SLEEP_CODE <= hwc_next & cfg_reg[4][`BVSC_B_HWCVSEL];
         BUCK2_HWC_MODE_OH        <= hwc_next ? mode_oh(cfg_reg[4][`BVSC_F_HWCMODE]) : 4'h0;
      end
   end

   // A fault is acted on at its rising edge only, so a stuck fault cannot retrigger resets.
   always @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         fault_d_reg      <= 1'b0;
         BUCK2_FAULT_IRQ  <= 1'b0;
         BUCK2_SHUTDOWN   <= 1'b0;
         SYSTEM_RESET_REQ <= 1'b0;
      end else begin
         fault_d_reg      <= fault_s;
         BUCK2_FAULT_IRQ  <= fault_s & ~fault_d_reg;
         BUCK2_SHUTDOWN   <= fault_s & ~fault_d_reg & (cfg_reg[4][`BVSC_F_ERRACT] == `BVSC_ERR_CONV);
         SYSTEM_RESET_REQ <= fault_s & ~fault_d_reg & (cfg_reg[4][`BVSC_F_ERRACT] == `BVSC_ERR_SYS);
      end
   end
endmodule

// >>> testbench/bvsc_checker.sv
// Purpose: Concurrent checks on the decoded outputs of the buck configuration block.
// Assumes: One clock domain; RST_N is asynchronous and active low.
// Notes:   Pin checks allow for the two-flop synchroniser, so some windows are two cycles wide.
`timescale 1ns/1ps
module bvsc_checker (
   input wire        CLOCK,
   input wire        RST_N,
   input wire        HW_ENABLE_ASSIGNED,
   input wire        BUCK2_FAULT,
   input wire        CFG_LOADING,
   input wire [14:0] BUCK1_RUN_VOLTAGE,
   input wire [14:0] BUCK1_SLEEP_VOLTAGE,
   input wire [14:0] BUCK1_SCALING_VOLTAGE,
   input wire [14:0] BUCK1_TARGET_VOLTAGE,
   input wire        BUCK1_SCALING_ACTIVE,
   input wire [2:0]  BUCK1_SLEEP_TIMESLOT,
   input wire        BUCK1_SLEEP_DISABLES,
   input wire [3:0]  BUCK1_SLEEP_MODE_OH,
   input wire        BUCK2_FREQ_2MHZ,
   input wire        BUCK2_FREQ_4MHZ,
   input wire        BUCK2_HWC_ACTIVE,
   input wire [3:0]  BUCK2_HWC_MODE_OH,
   input wire        BUCK2_FAULT_IRQ,
   input wire        BUCK2_SHUTDOWN,
   input wire        SYSTEM_RESET_REQ
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);
   // Levels are in 0.1 mV, so a legal level sits on the 12.5 mV grid.
   function automatic bit on_grid(input [14:0] v);
      on_grid = v >= 15'h1770 && v <= 15'h4650 && (v - 15'h1770) % 15'h007d == 15'h0000;
   endfunction
   AST_LEVEL_GRID: assert property (on_grid(BUCK1_RUN_VOLTAGE) && on_grid(BUCK1_SLEEP_VOLTAGE)
      && on_grid(BUCK1_SCALING_VOLTAGE)) else $error("Level off grid.");
   AST_TARGET_PICK: assert property ($stable(BUCK1_SCALING_ACTIVE) && $stable(BUCK1_RUN_VOLTAGE)
      && $stable(BUCK1_SCALING_VOLTAGE) |-> BUCK1_TARGET_VOLTAGE ==
      (BUCK1_SCALING_ACTIVE ? BUCK1_SCALING_VOLTAGE : BUCK1_RUN_VOLTAGE)) else $error("Target wrong.");
   AST_SLOT_RANGE: assert property (BUCK1_SLEEP_TIMESLOT >= 3'h1 && BUCK1_SLEEP_TIMESLOT <= 3'h5)
      else $error("Timeslot out of range.");
   AST_HWEN_NO_DISABLE: assert property (HW_ENABLE_ASSIGNED && $past(HW_ENABLE_ASSIGNED) &&
      $past(HW_ENABLE_ASSIGNED, 2) && $past(HW_ENABLE_ASSIGNED, 3) |-> !BUCK1_SLEEP_DISABLES)
      else $error("Disable with hardware enable.");
   AST_MODE_ONEHOT: assert property ($onehot(BUCK1_SLEEP_MODE_OH)) else $error("Sleep mode not one-hot.");
   AST_FREQ_EXCL: assert property (!(BUCK2_FREQ_2MHZ && BUCK2_FREQ_4MHZ)) else $error("Two rates.");
   AST_FREQ_LOAD_ONLY: assert property ($changed(BUCK2_FREQ_2MHZ) || $changed(BUCK2_FREQ_4MHZ) |->
      $past(CFG_LOADING, 2) || $past(CFG_LOADING, 3) || $past(CFG_LOADING, 4) || $past(CFG_LOADING, 5))
      else $error("Rate changed outside load.");
   AST_HWC_MODE: assert property (BUCK2_HWC_ACTIVE == $past(BUCK2_HWC_ACTIVE) |->
      (BUCK2_HWC_ACTIVE ? $onehot(BUCK2_HWC_MODE_OH) : BUCK2_HWC_MODE_OH == 4'h0)) else $error("Mode wrong.");
   AST_FAULT_IRQ: assert property ($rose(BUCK2_FAULT) |-> ##[2:3] BUCK2_FAULT_IRQ)
      else $error("Fault raised no interrupt.");
   AST_IRQ_PULSE: assert property (BUCK2_FAULT_IRQ |=> !BUCK2_FAULT_IRQ) else $error("Long pulse.");
   AST_ACTION_IRQ: assert property (BUCK2_SHUTDOWN || SYSTEM_RESET_REQ |-> BUCK2_FAULT_IRQ &&
      !(BUCK2_SHUTDOWN && SYSTEM_RESET_REQ)) else $error("Action without interrupt.");
   COV_SYS_RESET: cover property (BUCK2_FAULT_IRQ && SYSTEM_RESET_REQ);
   COV_FREQ_4M: cover property ($rose(BUCK2_FREQ_4MHZ));
   COV_SCALING: cover property ($rose(BUCK1_SCALING_ACTIVE));
endmodule

bind bvsc_top bvsc_checker u_bvsc_checker (.CLOCK(CLOCK), .RST_N(RST_N), .HW_ENABLE_ASSIGNED(HW_ENABLE_ASSIGNED),
   .BUCK2_FAULT(BUCK2_FAULT), .CFG_LOADING(CFG_LOADING), .BUCK1_RUN_VOLTAGE(BUCK1_RUN_VOLTAGE),
   .BUCK1_SLEEP_VOLTAGE(BUCK1_SLEEP_VOLTAGE), .BUCK1_SCALING_VOLTAGE(BUCK1_SCALING_VOLTAGE),
   .BUCK1_TARGET_VOLTAGE(BUCK1_TARGET_VOLTAGE), .BUCK1_SCALING_ACTIVE(BUCK1_SCALING_ACTIVE),
   .BUCK1_SLEEP_TIMESLOT(BUCK1_SLEEP_TIMESLOT), .BUCK1_SLEEP_DISABLES(BUCK1_SLEEP_DISABLES),
   .BUCK1_SLEEP_MODE_OH(BUCK1_SLEEP_MODE_OH), .BUCK2_FREQ_2MHZ(BUCK2_FREQ_2MHZ), .BUCK2_FREQ_4MHZ(BUCK2_FREQ_4MHZ),
   .BUCK2_HWC_ACTIVE(BUCK2_HWC_ACTIVE), .BUCK2_HWC_MODE_OH(BUCK2_HWC_MODE_OH), .BUCK2_FAULT_IRQ(BUCK2_FAULT_IRQ),
   .BUCK2_SHUTDOWN(BUCK2_SHUTDOWN), .SYSTEM_RESET_REQ(SYSTEM_RESET_REQ));

// >>> testbench/bvsc_top_tb.sv
// Purpose: Self-checking bench for the buck voltage and slot configuration block.
// Assumes: AXI4-Lite master tasks; every input changes by non-blocking assignment after a rising edge.
// Notes:   The rate tests run first so that codes above 48h are never written at 4 MHz.
`timescale 1ns/1ps
`include "bvsc_consts.vh"
module bvsc_top_tb;
   logic        clk, rst_n, hw_en, sc1, sc2, hc1, hc2, fault, loading, aw_valid, w_valid, b_ready, ar_valid;
   logic        r_ready, sd, rs, act, hact;
   logic [31:0] aw_addr, w_data, ar_addr, rdv, lfsr;
   logic [4:0]  otp_hi;
   logic [1:0]  resp;
   wire         aw_ready, w_ready, b_valid, ar_ready, r_valid, scl_act, slp_dis, f2, f4, cap_ok, hwc_act;
   wire         hwc_slp, irq, shut, sys_rst;
   wire  [1:0]  b_resp, r_resp;
   wire  [31:0] r_data;
   wire  [14:0] v_run, v_slp, v_scl, v_tgt;
   wire  [2:0]  slot_ts;
   wire  [3:0]  slp_mode, hwc_mode;
   integer      miscompares, num_checks, cycles, i, j, got;
   logic [31:0] dv [4];
   logic [15:0] idx_t [5] = '{`BVSC_IDX_RUN, `BVSC_IDX_SLEEP, `BVSC_IDX_SCALE, `BVSC_IDX_B2B, `BVSC_IDX_B2A};
   logic [15:0] msk_t [4] = '{`BVSC_MASK_RUN, `BVSC_MASK_SLEEP, `BVSC_MASK_SCALE, `BVSC_MASK_B2B};
   logic [15:0] rst_t [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0300, 16'h8000};
   logic [15:0] fw_t [6] = '{16'h8302, 16'h8000, 16'h8101, 16'h8202, 16'h8303, 16'h8102};
   logic [15:0] fe_t [6] = '{16'h8000, 16'h8000, 16'h8101, 16'h8202, 16'h8303, 16'h8303};
   logic [6:0]  corner [6] = '{7'h08, 7'h09, 7'h48, 7'h67, 7'h68, 7'h7f};

   bvsc_top dut (
      .CLOCK(clk), .RST_N(rst_n), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready),
      .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready),
      .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr),
      .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp),
      .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready), .HW_ENABLE_ASSIGNED(hw_en), .HW_SCALING_INPUT_1(sc1),
      .HW_SCALING_INPUT_2(sc2), .HW_CTRL_INPUT_1(hc1), .HW_CTRL_INPUT_2(hc2), .BUCK2_FAULT(fault),
      .CFG_LOADING(loading), .OTP_RUN_CODE_HI(otp_hi), .BUCK1_RUN_VOLTAGE(v_run), .BUCK1_SLEEP_VOLTAGE(v_slp),
      .BUCK1_SCALING_VOLTAGE(v_scl), .BUCK1_TARGET_VOLTAGE(v_tgt), .BUCK1_SCALING_ACTIVE(scl_act),
      .BUCK1_SLEEP_TIMESLOT(slot_ts), .BUCK1_SLEEP_DISABLES(slp_dis), .BUCK1_SLEEP_MODE_OH(slp_mode),
      .BUCK2_FREQ_2MHZ(f2), .BUCK2_FREQ_4MHZ(f4), .BUCK2_CAP_VALID(cap_ok), .BUCK2_HWC_ACTIVE(hwc_act),
      .BUCK2_HWC_USE_SLEEP_CODE(hwc_slp), .BUCK2_HWC_MODE_OH(hwc_mode), .BUCK2_FAULT_IRQ(irq),
      .BUCK2_SHUTDOWN(shut), .SYSTEM_RESET_REQ(sys_rst));

   function automatic [31:0] nxt(input [31:0] s);
      nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic [14:0] vlev(input [6:0] c);
      vlev = c <= 7'h08 ? 15'h1770 : c >= 7'h68 ? 15'h4650 : 15'h1770 + 15'h007d * (c - 7'h08);
   endfunction
   function automatic [2:0] tslot(input [2:0] s);
      tslot = s == 3'h0 ? 3'h5 : s == 3'h6 ? 3'h3 : s == 3'h7 ? 3'h1 : 3'h6 - s;
   endfunction
   function automatic [31:0] ba(input [15:0] idx);
      ba = {14'h0000, idx, 2'h0};
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test;
      if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // The decoded outputs trail the register by one edge and the pins by three, so six edges cover both.
   task automatic settle;
      repeat (6) @(posedge clk);
      #1;
   endtask
   task automatic wr(input [31:0] a, input [31:0] d);
      @(posedge clk);
      aw_addr <= a;
      w_data <= d;
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      b_ready <= 1'b1;
      do begin
         @(posedge clk);
         if (aw_ready === 1'b1) aw_valid <= 1'b0;
         if (w_ready === 1'b1) w_valid <= 1'b0;
      end while (aw_valid || w_valid);
      do @(posedge clk); while (b_valid !== 1'b1);
      resp = b_resp;
      b_ready <= 1'b0;
   endtask
   task automatic rd(input [31:0] a);
      @(posedge clk);
      ar_addr <= a;
      ar_valid <= 1'b1;
      r_ready <= 1'b1;
      do @(posedge clk); while (ar_ready !== 1'b1);
      ar_valid <= 1'b0;
      do @(posedge clk); while (r_valid !== 1'b1);
      rdv = r_data;
      resp = r_resp;
      r_ready <= 1'b0;
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         miscompares = miscompares + 1;
         finish_test;
      end
   end

   initial begin
      {rst_n, hw_en, sc1, sc2, hc1, hc2, fault, loading, aw_valid, w_valid, b_ready, ar_valid, r_ready} = 13'h0000;
      {aw_addr, w_data, ar_addr} = 96'h0;
      otp_hi = 5'h12;
      lfsr = 32'h00017d84;
      {miscompares, num_checks, cycles} = 96'h0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk("slot_rst", slot_ts, 3'h5);
      chk("levels_rst", {v_slp, v_scl}, {15'h1770, 15'h1770});
      for (i = 0; i < 5; i++) begin
         rd(ba(idx_t[i]));
         chk("reg_rst", rdv, {16'h0000, rst_t[i]});
      end
      // Rate and capacitor fields: locked, then loading, then locked again.
      for (i = 0; i < 6; i++) begin
         @(posedge clk);
         loading <= i >= 1 && i <= 4;
         settle;
         if (i == 1) chk("otp_run", v_run, vlev({otp_hi, 2'h0}));
         wr(ba(`BVSC_IDX_B2A), {16'h0000, fw_t[i]});
         chk("wr_resp", resp, `BVSC_RESP_OKAY);
         settle;
         rd(ba(`BVSC_IDX_B2A));
         chk("b2a", rdv, {16'h0000, fe_t[i]});
         chk("rates", {f2, f4}, {fe_t[i][9:8] == 2'h1, fe_t[i][9:8] == 2'h2});
         chk("cap", cap_ok, fe_t[i][1:0] == 2'h2);
      end
      for (i = 0; i < 24; i++) begin
         for (j = 0; j < 4; j++) begin
            lfsr = nxt(lfsr);
            dv[j] = lfsr;
         end
         if (i < 6) dv[0][6:0] = corner[i];
         dv[1][15:13] = i[2:0];
         dv[1][9:8] = i[1:0];
         dv[2][12:11] = i[1:0];
         for (j = 0; j < 4; j++) wr(ba(idx_t[j]), dv[j]);
         {hw_en, sc1, sc2, hc1, hc2} <= lfsr[20:16];
         settle;
         for (j = 0; j < 4; j++) begin
            rd(ba(idx_t[j]));
            chk("readback", rdv, dv[j] & {16'h0000, msk_t[j]});
         end
         act = i[1:0] == 2'h1 || (i[1:0] == 2'h2 && sc1) || (i[1:0] == 2'h3 && sc2);
         hact = (dv[3][12:11] == 2'h1 && hc1) || (dv[3][12:11] == 2'h2 && hc2)
            || (dv[3][12:11] == 2'h3 && (hc1 || hc2));
         chk("run_v", v_run, vlev(dv[0][6:0]));
         chk("slp_v", v_slp, vlev(dv[1][6:0]));
         chk("scl_v", v_scl, vlev(dv[2][6:0]));
         chk("scl_act", {scl_act, v_tgt}, {act, act ? vlev(dv[2][6:0]) : vlev(dv[0][6:0])});
         chk("slot", slot_ts, tslot(i[2:0]));
         chk("no_4m", f4, 1'b0);
         chk("disable", slp_dis, i[2:0] >= 3'h1 && i[2:0] <= 3'h5 && !hw_en);
         chk("slp_mode", slp_mode, 4'h1 << i[1:0]);
         chk("hwc_act", {hwc_act, hwc_slp}, {hact, hact && dv[3][10]});
         chk("hwc_mode", hwc_mode, hact ? 4'h1 << dv[3][9:8] : 4'h0);
      end
      for (i = 0; i < 4; i++) begin
         wr(ba(`BVSC_IDX_B2B), {16'h0000, i[1:0], 14'h0000});
         {got, sd, rs} = 34'h0;
         fault <= 1'b1;
         repeat (8) begin
            @(posedge clk);
            #1;
            if (irq === 1'b1) {got, sd, rs} = {got + 1, shut, sys_rst};
         end
         @(posedge clk);
         fault <= 1'b0;
         chk("irq", got, 1);
         chk("action", {sd, rs}, {i == 1, i == 2});
         repeat (4) @(posedge clk);
      end
      rd(32'h00010174);
      chk("bad_rd_resp", resp, `BVSC_RESP_SLVERR);
      chk("bad_rd_data", rdv, 32'h0);
      wr(32'h00010174, 32'h0000ffff);
      chk("bad_wr", resp, `BVSC_RESP_SLVERR);
      finish_test;
   end
endmodule
